// ---- hdl/ifm_unit.sv ----
// interrupt flag and mask unit: masks, clear-on-read flags, global enable, vector, halt wake
//
// Operation
// [RL1] nine sources: three timer taps, two stopwatch signals, four input lines
// [RL2] each source has a mask bit; one enables, zero masks
// [RL3] global enable flag, set by unmask op, cleared by mask op, gates all
// [RL4] accepting an interrupt clears the global enable flag in hardware
// [RL5] a halted core resumes when an interrupt occurs
// [RL6] input flag sets when an enabled input line is one
// [RL7] timer flags set on falling edges of 32, 8 and 2 Hz taps
// [RL8] stopwatch flags set on falling edges of 1 Hz and 10 Hz signals
// [RL9] every factor flag clears right after software reads its register
// [RL10] unused bits of mask and flag registers read as zero
// [RL11] reset clears all masks and flags
// [RL12] input mask at e8: bits 3..0 enable lines 3..0
// [RL13] stopwatch mask at ea: bit1 slow, bit0 fast, upper bits zero
// [RL14] timer mask at eb: bits 2,1,0 for 2, 8, 32 Hz; bit3 zero
// [RL15] input flag at ed bit0, other bits zero
// [RL16] stopwatch flags at ee: bit1 slow, bit0 fast, upper bits zero
// [RL17] timer flags at ef: bits 2,1,0 for 2, 8, 32 Hz
// [RL18] software reading flags while enabled must mind request timing races
// [RL19] vector is low three program counter bits, one per group
// [RL20] vector bit0 timer, bit1 stopwatch, bit2 input
// [RL21] timer and stopwatch flags set regardless of their masks
// [RL22] request stands while any flag and its mask are both one
`include "ifm_regs.svh"
`default_nettype none
module ifm_unit (
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register access from the core
  input wire logic [`IFM_ADDR_W-1:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire ifm_pkg::ifm_nibble_t wdata_in,
  output ifm_pkg::ifm_nibble_t rdata_out,
  output logic rvalid_out,
  // core control
  input wire logic unmask_all_op_in,
  input wire logic mask_all_op_in,
  input wire logic halt_op_in,
  input wire logic irq_ack_in,
  // sources
  input wire logic [3:0] input_line_in,
  input wire logic [2:0] clock_divider_chain_in,
  input wire logic [1:0] stopwatch_upper_digit_in,
  // to the core
  output logic irq_out,
  output ifm_pkg::ifm_vector_t vector_out,
  output logic gie_out,
  output logic halted_out
);
  import ifm_pkg::*;

  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_n;
  ifm_nibble_t input_mask_q;
  logic [1:0] sw_mask_q;
  logic [2:0] timer_mask_q;
  logic gie_q;
  ifm_core_state_e core_state_q;
  logic [2:0] timer_fall;
  logic [1:0] sw_fall;
  logic input_line_pending;
  logic stopwatch_slow_pending;
  logic stopwatch_fast_pending;
  logic timer_slow_pending;
  logic timer_mid_pending;
  logic timer_fast_pending;
  logic [1:0] sw_pend;
  logic [2:0] timer_pend;
  logic input_set;
  logic rd_input_flag;
  logic rd_sw_flags;
  logic rd_timer_flags;
  logic grp_timer;
  logic grp_sw;
  logic grp_input;
  logic request;
  ifm_nibble_t rdata_d;
  logic gie_d;
  logic irq_d;
  ifm_vector_t vector_d;
  logic halted_d;

  // two-flop release of the asynchronous reset
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n = rst_sync2_q;

  // address decode, used by both the mask writes and the clear strobes
  function automatic logic hit(input logic [`IFM_ADDR_W-1:0] a, input logic [`IFM_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // one if any source is high while its enable bit is one; narrower groups are zero-extended
  function automatic logic any_enabled(input ifm_nibble_t src, input ifm_nibble_t en);
    any_enabled = |(src & en);
  endfunction

  assign rd_input_flag = rd_in && hit(addr_in, `IFM_OFS_INPUT_FLAG);
  assign rd_sw_flags = rd_in && hit(addr_in, `IFM_OFS_SW_FLAGS);
  assign rd_timer_flags = rd_in && hit(addr_in, `IFM_OFS_TIMER_FLAGS);

  // input-line mask, all four bits stored
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      input_mask_q <= `IFM_RST_MASK; // RL11
    end else if (wr_in && hit(addr_in, `IFM_OFS_INPUT_MASK)) begin
      input_mask_q <= wdata_in; // RL12
    end
  end

  // stopwatch mask; bits 3..2 are never stored so they read zero
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sw_mask_q <= 2'h0; // RL11
    end else if (wr_in && hit(addr_in, `IFM_OFS_SW_MASK)) begin
      sw_mask_q <= wdata_in[1:0]; // RL13
    end
  end

  // timer mask; bit 3 is never stored so it reads zero
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      timer_mask_q <= 3'h0; // RL11
    end else if (wr_in && hit(addr_in, `IFM_OFS_TIMER_MASK)) begin
      timer_mask_q <= wdata_in[2:0]; // RL14
    end
  end

  // edge detection on the divider taps and stopwatch signals
  ifm_fall_edge #(.WIDTH(3)) u_timer_edge (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .level_in(clock_divider_chain_in),
    .fall_out(timer_fall)
  );
  ifm_fall_edge #(.WIDTH(2)) u_sw_edge (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .level_in(stopwatch_upper_digit_in),
    .fall_out(sw_fall)
  );

  // level-sensitive input set: a line held high re-sets the flag after a read
  assign input_set = any_enabled(input_line_in, input_mask_q); // RL6

  ifm_flag_bit u_input_flag (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .set_in(input_set),
    .clear_in(rd_input_flag), // RL9
    .flag_out(input_line_pending)
  );

  // timer and stopwatch flags ignore their masks
  ifm_flag_bit u_timer_fast (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .set_in(timer_fall[`IFM_BIT_TIMER_FAST]), // RL7 RL21
    .clear_in(rd_timer_flags), // RL9
    .flag_out(timer_fast_pending)
  );
  ifm_flag_bit u_timer_mid (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .set_in(timer_fall[`IFM_BIT_TIMER_MID]), // RL7 RL21
    .clear_in(rd_timer_flags),
    .flag_out(timer_mid_pending)
  );
  ifm_flag_bit u_timer_slow (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .set_in(timer_fall[`IFM_BIT_TIMER_SLOW]), // RL7 RL21
    .clear_in(rd_timer_flags),
    .flag_out(timer_slow_pending)
  );
  ifm_flag_bit u_sw_fast (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .set_in(sw_fall[`IFM_BIT_SW_FAST]), // RL8 RL21
    .clear_in(rd_sw_flags), // RL9
    .flag_out(stopwatch_fast_pending)
  );
  ifm_flag_bit u_sw_slow (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .set_in(sw_fall[`IFM_BIT_SW_SLOW]), // RL8 RL21
    .clear_in(rd_sw_flags),
    .flag_out(stopwatch_slow_pending)
  );

  assign sw_pend = {stopwatch_slow_pending, stopwatch_fast_pending};
  assign timer_pend = {timer_slow_pending, timer_mid_pending, timer_fast_pending};

  // group requests: flag and mask both one (input uses its flag alone), held until the flag is read
  assign grp_timer = any_enabled({1'b0, timer_pend}, {1'b0, timer_mask_q}); // RL2 RL22
  assign grp_sw = any_enabled({2'h0, sw_pend}, {2'h0, sw_mask_q}); // RL2 RL22
  assign grp_input = input_line_pending; // input flag can only set when unmasked
  assign request = grp_timer | grp_sw | grp_input; // RL1

  // read mux; unmapped addresses and unused bits read zero
  always_comb begin
    rdata_d = 4'h0; // RL10
    case (addr_in)
      `IFM_OFS_INPUT_MASK: rdata_d = input_mask_q;
      `IFM_OFS_SW_MASK: rdata_d = {2'h0, sw_mask_q}; // RL13
      `IFM_OFS_TIMER_MASK: rdata_d = {1'h0, timer_mask_q}; // RL14
      `IFM_OFS_INPUT_FLAG: rdata_d = {3'h0, input_line_pending}; // RL15
      `IFM_OFS_SW_FLAGS: rdata_d = {2'h0, sw_pend}; // RL16
      `IFM_OFS_TIMER_FLAGS: rdata_d = {1'h0, timer_pend}; // RL17
      default: rdata_d = 4'h0;
    endcase
  end

  // read data is registered, so it carries the flag value before the clear
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= 4'h0;
    end else if (rd_in) begin
      rdata_out <= rdata_d;
    end
  end

  // answer marker, one cycle after each read strobe
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_in;
    end
  end

  // next global enable; acceptance beats a simultaneous unmask op so no nested take
  always_comb begin
    gie_d = gie_q;
    if (irq_ack_in) begin
      gie_d = 1'b0; // RL4
    end else if (mask_all_op_in) begin
      gie_d = 1'b0; // RL3
    end else if (unmask_all_op_in) begin
      gie_d = 1'b1; // RL3
    end
  end

  // global enable flag
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gie_q <= `IFM_RST_GIE;
    end else begin
      gie_q <= gie_d;
    end
  end

  // request needs the enable now and next, so it drops in the edge of an accept or mask op
  assign irq_d = request && gie_q && gie_d; // RL3 RL22

  // vector bits, one per group with a flag and its mask both one
  always_comb begin
    vector_d = 3'h0;
    vector_d[`IFM_VEC_BIT_TIMER] = grp_timer; // RL19 RL20
    vector_d[`IFM_VEC_BIT_SW] = grp_sw; // RL20
    vector_d[`IFM_VEC_BIT_INPUT] = grp_input; // RL20
  end

  // request to the core
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_d;
    end
  end

  // group vector to the core
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      vector_out <= 3'h0;
    end else begin
      vector_out <= vector_d;
    end
  end

  // enable copy takes the next value, so it never trails an unmask op by a cycle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gie_out <= `IFM_RST_GIE;
    end else begin
      gie_out <= gie_d;
    end
  end

  // halt tracking: any unmasked request ends halt, even with the global flag clear
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      core_state_q <= IFM_RUN;
    end else begin
      case (core_state_q)
        IFM_RUN: begin
          if (halt_op_in) begin
            core_state_q <= IFM_HALTED;
          end
        end
        IFM_HALTED: begin
          if (request) begin
            core_state_q <= IFM_WAKE; // RL5
          end
        end
        IFM_WAKE: core_state_q <= IFM_RUN;
        default: core_state_q <= IFM_RUN;
      endcase
    end
  end

  // halted next value: raised by the halt op, dropped in the edge that sees the wake
  always_comb begin
    halted_d = 1'b0;
    case (core_state_q)
      IFM_RUN: halted_d = halt_op_in;
      IFM_HALTED: halted_d = !request; // RL5
      IFM_WAKE: halted_d = 1'b0;
      default: halted_d = 1'b0;
    endcase
  end

  // halted flag to the core
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      halted_out <= 1'b0;
    end else begin
      halted_out <= halted_d;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/ifm_regs.svh ----
// register offsets, field positions and reset values of the interrupt flag and mask unit
`ifndef IFM_REGS_SVH
`define IFM_REGS_SVH
`define IFM_ADDR_W 8
`define IFM_OFS_INPUT_MASK 8'he8
`define IFM_OFS_SW_MASK 8'hea
`define IFM_OFS_TIMER_MASK 8'heb
`define IFM_OFS_INPUT_FLAG 8'hed
`define IFM_OFS_SW_FLAGS 8'hee
`define IFM_OFS_TIMER_FLAGS 8'hef
`define IFM_BIT_TIMER_FAST 0
`define IFM_BIT_TIMER_MID 1
`define IFM_BIT_TIMER_SLOW 2
`define IFM_BIT_SW_FAST 0
`define IFM_BIT_SW_SLOW 1
`define IFM_BIT_INPUT_PEND 0
`define IFM_VEC_BIT_TIMER 0
`define IFM_VEC_BIT_SW 1
`define IFM_VEC_BIT_INPUT 2
`define IFM_RST_MASK 4'h0
`define IFM_RST_FLAG 4'h0
`define IFM_RST_GIE 1'b0
`endif

// ---- hdl/ifm_pkg.sv ----
// types shared by the interrupt flag and mask unit
`default_nettype none
package ifm_pkg;
  typedef logic [3:0] ifm_nibble_t;
  typedef logic [2:0] ifm_vector_t;
  typedef enum logic [1:0] {
    IFM_RUN = 2'b00,
    IFM_HALTED = 2'b01,
    IFM_WAKE = 2'b11
  } ifm_core_state_e;
endpackage
`default_nettype wire

// ---- hdl/ifm_fall_edge.sv ----
// falling edge detector for one group of divider taps or stopwatch signals
`default_nettype none
module ifm_fall_edge #(
  parameter int WIDTH = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] prev_q;

  // previous level; reset to zero so no false edge right after reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_q <= '0;
    end else begin
      prev_q <= level_in;
    end
  end

  assign fall_out = prev_q & ~level_in;
endmodule
`default_nettype wire

// ---- hdl/ifm_flag_bit.sv ----
// one clear-on-read factor flag where a set beats a read in the same cycle
`default_nettype none
module ifm_flag_bit (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);
  // set wins over clear so an event landing on the read is kept
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/ifm_checker.sv ----
// port-level assertions for the interrupt flag and mask unit
`include "ifm_regs.svh"
`default_nettype none
module ifm_checker (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [`IFM_ADDR_W-1:0] addr_in,
  input wire logic rd_in,
  input wire ifm_pkg::ifm_nibble_t rdata_out,
  input wire logic rvalid_out,
  input wire logic unmask_all_op_in,
  input wire logic mask_all_op_in,
  input wire logic irq_ack_in,
  input wire logic [2:0] clock_divider_chain_in,
  input wire logic irq_out,
  input wire ifm_pkg::ifm_vector_t vector_out,
  input wire logic gie_out,
  input wire logic halted_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // taps held still long enough that no late edge can refill a flag
  sequence s_quiet;
    $stable(clock_divider_chain_in) [*2];
  endsequence
  sequence s_ef_read;
    rd_in && addr_in == `IFM_OFS_TIMER_FLAGS && $stable(clock_divider_chain_in);
  endsequence
  a_read_clears: assert property (s_quiet ##1 s_ef_read [*2] |=> rdata_out[2:0] == 3'h0)
    else $error("timer flags survived a read");
  a_ack_drops_gie: assert property (irq_ack_in |=> !gie_out && !irq_out)
    else $error("accept left global enable set");
  a_mask_op_wins: assert property (mask_all_op_in |=> !gie_out)
    else $error("mask op did not clear global enable");
  a_unmask_sets: assert property (unmask_all_op_in && !mask_all_op_in && !irq_ack_in |=> gie_out)
    else $error("unmask op did not set global enable");
  a_no_irq_off: assert property (!gie_out && !unmask_all_op_in |=> !irq_out)
    else $error("request while globally disabled");
  a_unused_zero: assert property (rvalid_out && $past(addr_in) != `IFM_OFS_INPUT_MASK |-> !rdata_out[3])
    else $error("unused bit 3 read as one");
  a_sw_upper_zero: assert property (rvalid_out && ($past(addr_in) == `IFM_OFS_SW_MASK
    || $past(addr_in) == `IFM_OFS_SW_FLAGS) |-> rdata_out[3:2] == 2'h0)
    else $error("stopwatch upper bits not zero");
  a_irq_has_vec: assert property (irq_out |-> vector_out != 3'h0)
    else $error("request with empty vector");
  // halted in one cycle, then a request shows on the vector: halt must already be left
  sequence s_halt_req;
    halted_out ##1 vector_out != 3'h0;
  endsequence
  a_halt_wakes: assert property (s_halt_req |-> !halted_out)
    else $error("core stayed halted with a request");
endmodule
`default_nettype wire

// ---- tb/ifm_core_model.sv ----
// behavioural core that accepts requests after a chosen wait
`default_nettype none
module ifm_core_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic accept_in,
  input wire logic [3:0] wait_in,
  input wire logic irq_in,
  output logic ack_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // one-cycle accept pulse; the count restarts so a held request is not taken twice
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 4'h0;
      ack_out <= 1'b0;
    end else begin
      ack_out <= 1'b0;
      if (!irq_in || ack_out || !accept_in) begin
        cnt_q <= 4'h0;
      end else if (cnt_q == wait_in) begin
        ack_out <= 1'b1;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/ifm_unit_tb_top.sv ----
// self-checking bench for the interrupt flag and mask unit
`default_nettype none
module ifm_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ifm_pkg::*;
  logic clk_in = 1'b0, reset_n_in = 1'b0, rd_in = 1'b0, wr_in = 1'b0, accept = 1'b0;
  logic unmask_op = 1'b0, mask_op = 1'b0, halt_op = 1'b0, irq_ack, rvalid, irq, gie, halted;
  logic [7:0] addr = 8'h00;
  logic [7:0] ofs[7] = '{8'he8, 8'hea, 8'heb, 8'hed, 8'hee, 8'hef, 8'he9};
  ifm_nibble_t msk[3] = '{4'hf, 4'h3, 4'h7};
  ifm_nibble_t wdata = 4'h0, rdata, r, exp_q[$];
  logic [3:0] lines = 4'h0, wait_n = 4'h2;
  logic [2:0] taps = 3'h7;
  logic [1:0] sw = 2'h3;
  ifm_vector_t vec;
  int error_cnt = 0, total_checks = 0;
  ifm_unit ifm_unit_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr), .rd_in(rd_in),
    .wr_in(wr_in), .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid), .unmask_all_op_in(unmask_op),
    .mask_all_op_in(mask_op), .halt_op_in(halt_op), .irq_ack_in(irq_ack), .input_line_in(lines),
    .clock_divider_chain_in(taps), .stopwatch_upper_digit_in(sw), .irq_out(irq), .vector_out(vec),
    .gie_out(gie), .halted_out(halted));
  ifm_core_model ifm_core_model_i (.clk_in(clk_in), .rst_n_in(reset_n_in), .accept_in(accept),
    .wait_in(wait_n), .irq_in(irq), .ack_out(irq_ack));
  initial forever #10 clk_in = ~clk_in;
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in) #2;
  endtask
  task automatic wr(input logic [7:0] a, input ifm_nibble_t d);
    tick(1);
    addr = a;
    wdata = d;
    wr_in = 1'b1;
    tick(1);
    wr_in = 1'b0;
  endtask
  // a second back-to-back read of a flag register must come back empty
  task automatic rd(input logic [7:0] a, input ifm_nibble_t e, input bit twice = 0);
    tick(1);
    addr = a;
    rd_in = 1'b1;
    exp_q.push_back(e);
    if (twice) begin
      tick(1);
      exp_q.push_back(4'h0);
    end
    tick(1);
    rd_in = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    tick(1);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 40) begin
      tick(1);
      n++;
    end
    chk({3'h0, s}, {3'h0, v});
  endtask
  // read answers are compared off the edge so registered outputs have settled
  always @(negedge clk_in) begin
    if (rvalid === 1'b1) begin
      chk(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 4'hx);
    end
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'he6d5));
    tick(2);
    reset_n_in = 1'b1;
    tick(3);
    foreach (ofs[i]) rd(ofs[i], 4'h0);
    for (int i = 0; i < 3; i++) begin
      r = 4'($urandom);
      wr(ofs[i], r);
      rd(ofs[i], r & msk[i]);
      wr(ofs[i], 4'h0);
    end
    wr(8'hef, 4'hf);
    rd(8'hef, 4'h0);
    $display("test 1 done");
    taps = 3'h0;
    sw = 2'h0;
    tick(4);
    chk({irq, vec}, 4'h0);
    rd(8'hef, 4'h7, 1);
    rd(8'hee, 4'h3, 1);
    taps = 3'h7;
    sw = 2'h3;
    lines = 4'hb;
    tick(3);
    rd(8'hed, 4'h0);
    wr(8'he8, 4'h4);
    rd(8'hed, 4'h0);
    lines = 4'h4;
    tick(2);
    lines = 4'h0;
    tick(2);
    rd(8'hed, 4'h1, 1);
    $display("test 2 done");
    wr(8'heb, 4'h1);
    lines = 4'h4;
    taps = 3'h6;
    tick(4);
    chk({1'b0, vec}, 4'h5);
    chk({3'h0, irq}, 4'h0);
    accept = 1'b1;
    pulse(unmask_op);
    wait_for(irq_ack, 1'b1);
    tick(2);
    chk({2'h0, gie, irq}, 4'h0);
    wait_n = 4'h0;
    pulse(unmask_op);
    tick(4);
    chk({2'h0, gie, irq}, 4'h0);
    pulse(unmask_op);
    pulse(mask_op);
    chk({3'h0, gie}, 4'h0);
    lines = 4'h0;
    taps = 3'h7;
    tick(2);
    rd(8'hed, 4'h1, 1);
    rd(8'hef, 4'h1, 1);
    $display("test 3 done");
    accept = 1'b0;
    pulse(halt_op);
    chk({3'h0, halted}, 4'h1);
    taps = 3'h6;
    wait_for(halted, 1'b0);
    chk({3'h0, halted}, 4'h0);
    rd(8'hef, 4'h1);
    $display("test 4 done");
    tick(3);
    chk(4'(exp_q.size()), 4'h0);
    wrap_up();
  end
endmodule
bind ifm_unit ifm_checker ifm_checker_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .unmask_all_op_in(unmask_all_op_in),
  .mask_all_op_in(mask_all_op_in), .irq_ack_in(irq_ack_in), .clock_divider_chain_in(clock_divider_chain_in),
  .irq_out(irq_out), .vector_out(vector_out), .gie_out(gie_out), .halted_out(halted_out));
`default_nettype wire
